// ### hdl/dsst_top.sv
// Contract
// - Segment miss with select bit routes out
// - Sixteen segment registers, format by select
// - Bit 0 is direct-store select
// - Keys, bus unit id, controller field
// - Supervisor uses supervisor key
// - User uses user key
// - No page walk, no reference/change
// - Attributes forced to 0b0101
// - Each bus transaction translated separately
// - No page protection for direct-store
// - Selected key sent to controller
// - Descriptor and address portions sent
// - Unsupported instructions raise data storage exception
// - Cache block ops become no-ops
// - FP alignment exception fixed by control
// - Descriptor consulted only on lookaside miss
`timescale 1ns/10ps
module dsst_top
  import dsst_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire dsst_req_t   REQ_I,
  output dsst_resp_t       RESP_O,
  output dsst_bus_t        BUS_O,
  output logic             IRQ_O
);

  logic [31:0] seg_reg [SEG_COUNT];
  logic [1:0]  ctrl_reg;
  logic [3:0]  status_reg;
  logic [3:0]  mask_reg;
  logic [31:0] cause_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  dsst_resp_t  resp_reg;
  dsst_bus_t   bus_reg;
  logic        irq_reg;

  logic        apb_access;
  logic        apb_wr;
  logic        addr_is_seg;
  logic        addr_known;
  logic [31:0] seg_sel;
  logic        xlate_on;
  logic        is_ds;
  logic        ds_access;
  logic [3:0]  ev_set;
  dsst_resp_t  resp_next;
  dsst_bus_t   bus_next;
  logic [31:0] rd_mux;

  // APB decode; access taken in the access phase, one wait state
  assign apb_access  = PSEL_I && PENABLE_I && !pready_reg;
  assign apb_wr      = apb_access && PWRITE_I;
  assign addr_is_seg = (PADDR_I < CTRL_ADDR) && (PADDR_I[1:0] == 2'h0);
  assign addr_known  = addr_is_seg || PADDR_I == CTRL_ADDR || PADDR_I == STATUS_ADDR ||
                       PADDR_I == MASK_ADDR || PADDR_I == CAUSE_ADDR;

  // Segment registers
  // sixteen descriptor bank
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        seg_reg[i] <= SEG_RESET;
      end
    end else if (apb_wr && addr_is_seg) begin
      seg_reg[PADDR_I[5:2]] <= PWDATA_I;
    end
  end

  // Control and mask registers
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
    end else if (apb_wr) begin
      if (PADDR_I == CTRL_ADDR) ctrl_reg <= PWDATA_I[1:0];
      if (PADDR_I == MASK_ADDR) mask_reg <= PWDATA_I[3:0];
    end
  end

  // Translation decode on the segment picked by the top address nibble
  assign seg_sel  = seg_reg[REQ_I.eff_addr[31:28]];
  assign xlate_on = ctrl_reg[CTRL_XLATE_POS];
  assign is_ds    = seg_sel[DS_SEL_POS];
  assign ds_access = REQ_I.valid && xlate_on && !REQ_I.block_area_hit &&
                     !REQ_I.lookaside_hit && is_ds;

  // Response and bus transaction build
  always_comb begin
    resp_next       = '0;
    bus_next        = '0;
    resp_next.valid = REQ_I.valid;
    if (REQ_I.valid && !ds_access) begin
      // Ordinary path: page walk only when not a lookaside hit
      resp_next.page_walk      = xlate_on && !REQ_I.block_area_hit && !REQ_I.lookaside_hit;
      resp_next.ref_chg_update = resp_next.page_walk;
      resp_next.page_protect   = resp_next.page_walk;
    end
    if (ds_access) begin
      resp_next.direct_store = 1'b1;
      resp_next.page_walk      = 1'b0;
      resp_next.ref_chg_update = 1'b0;
      resp_next.page_protect   = 1'b0;
      resp_next.storage_attribute_bits = DS_ATTR;
      case (REQ_I.op)
        DSST_OP_RESV,
        DSST_OP_EXTCTL: resp_next.dsi = 1'b1;
        DSST_OP_CACHE:  resp_next.noop = 1'b1;
        DSST_OP_FP_LDST: resp_next.align_exc = ctrl_reg[CTRL_FPALIGN_POS];
        default:        resp_next.noop = 1'b0;
      endcase
      if (!resp_next.dsi && !resp_next.noop && !resp_next.align_exc) begin
        bus_next.valid = 1'b1;
        // supervisor key when not problem state
        bus_next.key = REQ_I.problem_state ? seg_sel[USR_KEY_POS] : seg_sel[SUP_KEY_POS];
        bus_next.bus_unit_id               = seg_sel[BUS_UNIT_ID_MSB:BUS_UNIT_ID_LSB];
        bus_next.controller_specific_field = seg_sel[CSPEC_MSB:CSPEC_LSB];
        bus_next.eff_offset                = REQ_I.eff_addr[27:0];
        // Only plain stores are flagged as writes; the register bus plays no part here
        bus_next.is_write                  = (REQ_I.op == DSST_OP_STORE);
      end
    end
  end

  // Registered outputs toward core and I/O controller
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      resp_reg <= '0;
      bus_reg  <= '0;
    end else begin
      resp_reg <= resp_next;
      bus_reg  <= bus_next;
    end
  end

  // Events for status
  assign ev_set = {resp_next.align_exc, resp_next.noop, resp_next.dsi, bus_next.valid};

  // Sticky status, write one to clear, set wins
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      status_reg <= 4'h0;
    end else if (apb_wr && PADDR_I == STATUS_ADDR) begin
      status_reg <= (status_reg & ~PWDATA_I[3:0]) | ev_set;
    end else begin
      status_reg <= status_reg | ev_set;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cause_reg <= 32'h0000_0000;
    end else if (resp_next.dsi) begin
      cause_reg <= CAUSE_DS_UNSUP;
    end else if (apb_wr && PADDR_I == CAUSE_ADDR) begin
      cause_reg <= PWDATA_I;
    end
  end

  // Interrupt level
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |((status_reg | ev_set) & mask_reg &
                   ~((apb_wr && PADDR_I == STATUS_ADDR) ? (PWDATA_I[3:0] & ~ev_set) : 4'h0));
    end
  end

  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_is_seg) begin
      rd_mux = seg_reg[PADDR_I[5:2]];
    end else begin
      case (PADDR_I)
        CTRL_ADDR:   rd_mux = {30'h0, ctrl_reg};
        STATUS_ADDR: rd_mux = {28'h0, status_reg};
        MASK_ADDR:   rd_mux = {28'h0, mask_reg};
        CAUSE_ADDR:  rd_mux = cause_reg;
        default:     rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // APB answer: pready one cycle after access phase starts
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_access;
      pslverr_reg <= apb_access && !addr_known;
      prdata_reg  <= (apb_access && !PWRITE_I) ? rd_mux : 32'h0000_0000;
    end
  end

  assign PRDATA_O  = prdata_reg;
  assign PREADY_O  = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign RESP_O    = resp_reg;
  assign BUS_O     = bus_reg;
  assign IRQ_O     = irq_reg;

endmodule // dsst_top

// ### hdl/dsst_pkg.sv
package dsst_pkg;

  // Register map, byte addresses on the APB side
  localparam logic [7:0] SEG_BASE_ADDR     = 8'h00; // 16 segment registers at 0x00..0x3c
  localparam logic [7:0] CTRL_ADDR         = 8'h40;
  localparam logic [7:0] STATUS_ADDR       = 8'h44;
  localparam logic [7:0] MASK_ADDR         = 8'h48;
  localparam logic [7:0] CAUSE_ADDR        = 8'h4c;
  localparam logic [7:0] LAST_ADDR         = 8'h50;
  localparam int         SEG_COUNT         = 16;

  // Direct-store descriptor fields, big-endian bit numbers mapped to [31:0]
  localparam int         DS_SEL_POS        = 31;    // bit 0
  localparam int         SUP_KEY_POS       = 30;    // bit 1
  localparam int         USR_KEY_POS       = 29;    // bit 2
  localparam int         BUS_UNIT_ID_MSB          = 28;    // bits 3..11
  localparam int         BUS_UNIT_ID_LSB          = 20;
  localparam int         CSPEC_MSB         = 19;    // bits 12..31
  localparam int         CSPEC_LSB         = 0;

  // Control bit positions
  localparam int         CTRL_XLATE_POS    = 0;
  localparam int         CTRL_FPALIGN_POS  = 1;

  // Status / mask bit positions
  localparam int         ST_ROUTE_POS      = 0;
  localparam int         ST_DSI_POS        = 1;
  localparam int         ST_NOOP_POS       = 2;
  localparam int         ST_ALIGN_POS      = 3;

  // Reset values
  localparam logic [31:0] SEG_RESET        = 32'h0000_0000;
  localparam logic [1:0]  CTRL_RESET       = 2'h1;
  localparam logic [3:0]  MASK_RESET       = 4'h0;

  // Forced storage attributes for direct-store: caching inhibited, guarded
  localparam logic [3:0]  DS_ATTR          = 4'h5;
  // Cause register value: direct-store unsupported instruction
  localparam logic [31:0] CAUSE_DS_UNSUP   = 32'h0400_0000;

  // Kind of access presented by the core
  typedef enum logic [2:0] {
    DSST_OP_LOAD,
    DSST_OP_STORE,
    DSST_OP_FP_LDST,
    DSST_OP_RESV,     // load-reserved / store-conditional
    DSST_OP_EXTCTL,   // external control in / out
    DSST_OP_CACHE     // data or instruction cache block op
  } dsst_op_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] eff_addr;
    dsst_op_t    op;
    logic        problem_state;
    logic        block_area_hit;
    logic        lookaside_hit;
  } dsst_req_t;

  typedef struct packed {
    logic        valid;
    logic        key;
    logic [8:0]  bus_unit_id;
    logic [19:0] controller_specific_field;
    logic [27:0] eff_offset;
    logic        is_write;
  } dsst_bus_t;

  typedef struct packed {
    logic       valid;
    logic       direct_store;
    logic       page_walk;
    logic       ref_chg_update;
    logic       page_protect;
    logic       noop;
    logic       dsi;
    logic       align_exc;
    logic [3:0] storage_attribute_bits;
  } dsst_resp_t;

endpackage

// ### testbench/dsst_ctrl_model.sv
`timescale 1ns/10ps
module dsst_ctrl_model
  import dsst_pkg::*;
(
  input  wire logic      clk_i,
  input  wire dsst_bus_t bus_i,
  output int             seen_o
);
  // Counts transfers; key accepted, no checking
  // no protection enforced
  always_ff @(posedge clk_i) begin
    if (bus_i.valid) begin
      seen_o <= seen_o + 1;
    end
  end
endmodule // dsst_ctrl_model

// ### testbench/dsst_top_properties.sv
`timescale 1ns/10ps
module dsst_top_properties
  import dsst_pkg::*;
(
  input wire logic       CLOCK_I,
  input wire logic       RST_N_I,
  input wire dsst_req_t  REQ_I,
  input wire dsst_resp_t RESP_O,
  input wire dsst_bus_t  BUS_O,
  input wire logic       IRQ_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // Translation outcome relations
  AST_ATTR: assert property (RESP_O.direct_store |-> RESP_O.storage_attribute_bits == DS_ATTR)
    else $error("attributes wrong");
  AST_NO_WALK: assert property (RESP_O.direct_store |-> !RESP_O.page_walk && !RESP_O.ref_chg_update)
    else $error("page walk seen");
  AST_NO_PROT: assert property (RESP_O.direct_store |-> !RESP_O.page_protect)
    else $error("page protection seen");
  AST_EACH: assert property (REQ_I.valid |=> RESP_O.valid)
    else $error("request lost");
  AST_OFFSET: assert property (REQ_I.valid ##1 BUS_O.valid |-> BUS_O.eff_offset == $past(REQ_I.eff_addr[27:0]))
    else $error("offset wrong");
  AST_MISS: assert property (REQ_I.valid && (REQ_I.lookaside_hit || REQ_I.block_area_hit) |=> !BUS_O.valid)
    else $error("routed on hit");
  AST_DSI: assert property (RESP_O.dsi |-> !BUS_O.valid)
    else $error("bus on exception");
  AST_NOOP: assert property (RESP_O.noop |-> !BUS_O.valid && !RESP_O.dsi)
    else $error("noop had effect");
  AST_BUS_DS: assert property (BUS_O.valid |-> RESP_O.direct_store && !RESP_O.noop && !RESP_O.align_exc)
    else $error("bus without direct-store");
  // Main scenarios
  cover property (BUS_O.valid);
  cover property (RESP_O.noop);
  cover property (RESP_O.dsi);
  cover property (IRQ_O);
endmodule // dsst_top_properties

bind dsst_top dsst_top_properties chk_i (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .REQ_I(REQ_I),
  .RESP_O(RESP_O), .BUS_O(BUS_O), .IRQ_O(IRQ_O));

// ### testbench/direct_store_segment_translation_test.sv
`timescale 1ns/10ps
module direct_store_segment_translation_test import dsst_pkg::*;;
  logic        CLOCK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, IRQ_O, e;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, q, cause_m, seg [16];
  logic [1:0]  ctrl;
  logic [3:0]  st;
  dsst_req_t   REQ_I;
  dsst_resp_t  RESP_O;
  dsst_bus_t   BUS_O;
  int          err_total, checks, nbus, seen;

  dsst_top dut (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .REQ_I(REQ_I), .RESP_O(RESP_O), .BUS_O(BUS_O), .IRQ_O(IRQ_O));
  dsst_ctrl_model far (.clk_i(CLOCK_I), .bus_i(BUS_O), .seen_o(seen));

  // Clock and watchdog
  initial begin
    CLOCK_I = 0;
    forever #20 CLOCK_I = ~CLOCK_I;
  end
  initial begin
    #200us;
    err_total++;
    report_and_stop();
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK_I);
    PSEL_I   <= 1'b1;
    PWRITE_I <= w;
    PADDR_I  <= a;
    PWDATA_I <= d;
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge CLOCK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 20);
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I    <= 1'b0;
    PENABLE_I <= 1'b0;
    if (n >= 20) err_total++;
  endtask

  // Random requests back to back, checked one cycle later
  task automatic run(input int cnt);
    dsst_req_t   r;
    dsst_resp_t  er;
    dsst_bus_t   eb;
    logic        ds, pend;
    logic [31:0] s;
    pend = 0;
    ds = 0;
    for (int i = 0; i <= cnt; i++) begin
      @(posedge CLOCK_I);
      r = '0;
      if (i < cnt) begin
        r.valid = $urandom_range(3) != 0;
        r.eff_addr = $urandom;
        r.op = dsst_op_t'($urandom_range(5));
        r.problem_state = $urandom_range(1);
        r.block_area_hit = $urandom_range(3) == 0;
        r.lookaside_hit = $urandom_range(3) == 0;
      end
      REQ_I <= r;
      #1;
      if (pend && ds) begin
        chk(RESP_O, er);
        chk(eb.valid ? BUS_O : BUS_O.valid, eb.valid ? eb : 0);
      end else if (pend) chk({RESP_O.valid, RESP_O.direct_store, BUS_O.valid}, 3'b100);
      s = seg[r.eff_addr[31:28]];
      pend = r.valid;
      ds = r.valid && ctrl[0] && !r.block_area_hit && !r.lookaside_hit && s[31];
      er = '0;
      er.valid = 1'b1;
      er.direct_store = 1'b1;
      er.storage_attribute_bits = DS_ATTR;
      er.dsi = r.op inside {DSST_OP_RESV, DSST_OP_EXTCTL};
      er.noop = r.op == DSST_OP_CACHE;
      er.align_exc = r.op == DSST_OP_FP_LDST && ctrl[1];
      eb = {!(er.dsi || er.noop || er.align_exc), r.problem_state ? s[29] : s[30], s[28:0],
            r.eff_addr[27:0], r.op == DSST_OP_STORE};
      if (ds) begin
        st = st | {er.align_exc, er.noop, er.dsi, eb.valid};
        nbus += eb.valid;
        if (er.dsi) cause_m = CAUSE_DS_UNSUP;
      end
    end
  endtask

  // Main sequence
  initial begin
    RST_N_I = 0;
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = '0;
    REQ_I = '0;
    st = 0;
    cause_m = 0;
    void'($urandom(32'hdf673da4));
    repeat (3) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    apb(0, CTRL_ADDR, 0);
    chk(q, 1);
    apb(0, 8'h60, 0);
    chk({e, q}, 33'h100000000);
    for (int i = 0; i < SEG_COUNT; i++) begin
      seg[i] = $urandom;
      apb(1, SEG_BASE_ADDR + 8'(4 * i), seg[i]);
      apb(0, SEG_BASE_ADDR + 8'(4 * i), 0);
      chk(q, seg[i]);
    end
    ctrl = 2'h1;
    run(300);
    apb(1, CTRL_ADDR, 32'h3);
    ctrl = 2'h3;
    run(300);
    apb(1, CTRL_ADDR, 32'h0);
    ctrl = 2'h0;
    run(100);
    apb(0, STATUS_ADDR, 0);
    chk(q, st);
    apb(0, CAUSE_ADDR, 0);
    chk(q, cause_m);
    chk(IRQ_O, 0);
    apb(1, MASK_ADDR, 32'hf);
    repeat (2) @(posedge CLOCK_I);
    chk(IRQ_O, 1);
    apb(1, STATUS_ADDR, 32'hf);
    repeat (2) @(posedge CLOCK_I);
    chk(IRQ_O, 0);
    chk(seen, nbus);
    report_and_stop();
  end
endmodule // direct_store_segment_translation_test
